// ---- rtl/jpd_pkg.sv ----
// shared constants and types for the test-port programming data path
package jpd_pkg;
    localparam int IR_W = 4;
    localparam int UNLOCK_W = 16;
    localparam int CMD_W = 15;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam logic [IR_W-1:0] IR_UNLOCK = 4'h4;
    localparam logic [IR_W-1:0] IR_CMD = 4'h5;
    localparam logic [IR_W-1:0] IR_PLOAD = 4'h6;
    localparam logic [IR_W-1:0] IR_PREAD = 4'h7;
    localparam logic [IR_W-1:0] IR_RESET = 4'hc;
    localparam logic [UNLOCK_W-1:0] UNLOCK_SIG = 16'ha370;
    localparam logic [UNLOCK_W-1:0] UNLOCK_RST = 16'h0000;
    localparam logic [CMD_W-1:0] CMD_RST = 15'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam int CLK_NS = 100;
    // page buffer write must land within this many link clocks after update
    localparam int PBUF_LIMIT_TCK = 11;
    localparam int TCK_NS = 800;
    localparam int PBUF_LIMIT_NS = PBUF_LIMIT_TCK * TCK_NS;
    localparam int PBUF_LIMIT_CYC = (PBUF_LIMIT_NS / CLK_NS) > 0 ? (PBUF_LIMIT_NS / CLK_NS) : 1;
    // default reset time-out, counted in system clocks
    localparam int RST_TIMEOUT_CYC = 64;
    localparam int RST_CNT_W = 16;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic idle;
    } jpd_tap_t;

    typedef struct packed {
        logic hi;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } jpd_pbuf_t;
endpackage

// ---- rtl/jpd_fifo.sv ----
// small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module jpd_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic en_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rp_q];
    assign push = en_i && in_valid_i && in_ready_o;
    assign pop = en_i && out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wp_q] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- rtl/jpd_top.sv ----
// programming data registers behind the test access port, sampled on the system clock
// Contract
// [RL1] page load selects byte alias of command
// [RL2] update copies byte, buffers within 11 clocks
// [RL3] page load alternates low then high
// [RL4] address pre-increments before low, except first
// [RL5] page read captures low then high bytes
// [RL6] address post-increments after every high byte
// [RL7] reset chain one holds device reset
// [RL8] reset persists for time-out after clear
// [RL9] programmer resets device before unlocking
// [RL10] programming enabled only on signature match
// [RL11] unlock register clears on power-on
// [RL12] 15-bit command shifts new, returns result
// [RL13] programmer chip erase command sequence
// [RL14] programmer flash write load sequence
// [RL15] programmer latch, commit and poll sequence
// [RL16] flash read returns low then high
// [RL17] programmer eeprom write sequence
// [RL18] all shift registers move lsb first
// [RL19] idle cycle executes last updated command
// [RL20] 4-bit instruction selects data registers
// [RL21] programmer may skip redundant first word
`timescale 1ns/1ps
module jpd_top (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire logic [3:0] tap_state_i,
    input wire logic [3:0] ir_i,
    input wire logic [7:0] cmd_result_i,
    input wire logic [7:0] flash_rdata_i,
    output logic tdo_o,
    output logic device_reset_o,
    output logic unlock_instr_o,
    output logic [14:0] cmd_o,
    output logic cmd_exec_o,
    output logic [15:0] flash_addr_o,
    output logic pbuf_we_o,
    output logic pbuf_hi_o,
    output logic [7:0] pbuf_data_o,
    output logic [15:0] pbuf_addr_o
);
    // tap_state_i bits: {capture, shift, update, idle}, decoded by the tap controller
    localparam int W = $bits(jpd_pkg::jpd_pbuf_t);

    logic [2:0] tck_s_q;
    logic [2:0] tdi_s_q;
    logic [3:0] st_s1_q;
    logic [3:0] st_s2_q;
    logic [3:0] st_s3_q;
    logic tck_rise;
    logic tck_fall;
    logic tck_lvl_q;
    jpd_pkg::jpd_tap_t tap;

    logic [jpd_pkg::UNLOCK_W-1:0] unlock_q;
    logic [jpd_pkg::CMD_W-1:0] cmd_sr_q;
    logic [jpd_pkg::CMD_W-1:0] cmd_q;
    logic rst_chain_q;
    logic [jpd_pkg::RST_CNT_W-1:0] rst_cnt_q;
    logic [jpd_pkg::ADDR_W-1:0] addr_q;
    logic pl_hi_q;
    logic pl_first_q;
    logic pr_hi_q;
    logic [jpd_pkg::BYTE_W-1:0] tmp_q;
    logic [3:0] ir_prev_q;
    logic upd_q;
    logic ir_new;
    logic pl_hi_cur;
    logic pl_first_cur;
    logic pr_hi_cur;

    jpd_pkg::jpd_pbuf_t fifo_in;
    jpd_pkg::jpd_pbuf_t fifo_out;
    logic fifo_in_valid_q;
    logic fifo_in_ready;
    logic fifo_out_valid;

    function automatic logic ir_is(input logic [3:0] ir, input logic [3:0] code);
        return ir == code;
    endfunction

    // three-stage sampling; a change counts once stages two and three agree
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tck_s_q <= '0;
            tdi_s_q <= '0;
            st_s1_q <= '0;
            st_s2_q <= '0;
            st_s3_q <= '0;
            tck_lvl_q <= 1'b0;
        end else if (clk_en_i) begin
            tck_s_q <= {tck_s_q[1:0], tck_i};
            tdi_s_q <= {tdi_s_q[1:0], tdi_i};
            st_s1_q <= tap_state_i;
            st_s2_q <= st_s1_q;
            st_s3_q <= st_s2_q;
            if (tck_s_q[1] == tck_s_q[2]) begin
                tck_lvl_q <= tck_s_q[2];
            end
        end
    end

    assign tck_rise = clk_en_i && (tck_s_q[1] == tck_s_q[2]) && tck_s_q[2] && !tck_lvl_q;
    assign tck_fall = clk_en_i && (tck_s_q[1] == tck_s_q[2]) && !tck_s_q[2] && tck_lvl_q;
    assign tap = jpd_pkg::jpd_tap_t'(st_s3_q);

    // a fresh instruction restarts alternation on its very first link edge,
    // so a capture on that same edge still counts as the first byte
    assign ir_new = (ir_prev_q != ir_i);
    assign pl_hi_cur = pl_hi_q && !ir_new;
    assign pl_first_cur = pl_first_q || ir_new;
    assign pr_hi_cur = pr_hi_q && !ir_new;

    // instruction entry tracking for the alternating byte sequencers
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_prev_q <= '0;
        end else if (tck_rise) begin
            ir_prev_q <= ir_i;
        end
    end

    // unlock signature register, lsb first
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_q <= jpd_pkg::UNLOCK_RST; // RL11
        end else if (tck_rise && tap.shift && ir_is(ir_i, jpd_pkg::IR_UNLOCK)) begin // RL20
            unlock_q <= {tdi_s_q[2], unlock_q[jpd_pkg::UNLOCK_W-1:1]}; // RL18
        end
    end

    // enable follows the compare only at update, as the register shifts through junk
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_instr_o <= 1'b0;
        end else if (tck_rise && tap.update && ir_is(ir_i, jpd_pkg::IR_UNLOCK)) begin
            unlock_instr_o <= (unlock_q == jpd_pkg::UNLOCK_SIG); // RL10
        end
    end

    // command shift register; low byte doubles as the page data byte
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_sr_q <= jpd_pkg::CMD_RST;
        end else if (tck_rise) begin
            if (ir_is(ir_i, jpd_pkg::IR_CMD) && tap.capture) begin
                cmd_sr_q <= {cmd_sr_q[14:8], cmd_result_i}; // RL12
            end else if (ir_is(ir_i, jpd_pkg::IR_CMD) && tap.shift) begin
                cmd_sr_q <= {tdi_s_q[2], cmd_sr_q[14:1]}; // RL12 RL18
            end else if (ir_is(ir_i, jpd_pkg::IR_PREAD) && tap.capture && unlock_instr_o) begin
                cmd_sr_q[7:0] <= flash_rdata_i; // RL5
            end else if ((ir_is(ir_i, jpd_pkg::IR_PLOAD) || ir_is(ir_i, jpd_pkg::IR_PREAD))
                         && tap.shift) begin
                cmd_sr_q[7:0] <= {tdi_s_q[2], cmd_sr_q[7:1]}; // RL1 RL18
            end
        end
    end

    // applied command and its single execute pulse from run-test/idle
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cmd_o <= jpd_pkg::CMD_RST;
            cmd_exec_o <= 1'b0;
        end else if (clk_en_i) begin
            cmd_exec_o <= 1'b0;
            if (tck_rise && unlock_instr_o && ir_is(ir_i, jpd_pkg::IR_CMD)) begin
                if (tap.update) begin
                    cmd_o <= cmd_sr_q;
                end
                if (tap.idle) begin
                    cmd_exec_o <= 1'b1; // RL19
                end
            end
        end
    end

    // reset chain: registered on the shift sample; device reset follows one system clock later
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_chain_q <= 1'b0;
        end else if (tck_rise && tap.shift && ir_is(ir_i, jpd_pkg::IR_RESET)) begin
            rst_chain_q <= tdi_s_q[2]; // RL7
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_cnt_q <= '0;
            device_reset_o <= 1'b0;
        end else if (clk_en_i) begin
            if (rst_chain_q) begin
                rst_cnt_q <= jpd_pkg::RST_CNT_W'(jpd_pkg::RST_TIMEOUT_CYC); // RL8
                device_reset_o <= 1'b1; // RL7
            end else if (rst_cnt_q != '0) begin
                rst_cnt_q <= rst_cnt_q - 1'b1; // RL8
                device_reset_o <= 1'b1;
            end else begin
                device_reset_o <= 1'b0;
            end
        end
    end

    // word address: set by load-address commands, stepped by page load/read
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_q <= jpd_pkg::ADDR_RST;
            pl_hi_q <= 1'b0;
            pl_first_q <= 1'b1;
            pr_hi_q <= 1'b0;
            upd_q <= 1'b0;
            tmp_q <= '0;
        end else if (clk_en_i) begin
            upd_q <= 1'b0;
            if (ir_new) begin
                pl_hi_q <= 1'b0; // RL3
                pl_first_q <= 1'b1; // RL4
                pr_hi_q <= 1'b0; // RL5
            end
            if (tck_rise && unlock_instr_o) begin
                if (ir_is(ir_i, jpd_pkg::IR_CMD) && tap.update) begin
                    if (cmd_sr_q[14:8] == 7'h07) begin
                        addr_q[15:8] <= cmd_sr_q[7:0];
                    end else if (cmd_sr_q[14:8] == 7'h03) begin
                        addr_q[7:0] <= cmd_sr_q[7:0];
                    end
                end
                if (ir_is(ir_i, jpd_pkg::IR_PLOAD) && tap.update) begin
                    tmp_q <= cmd_sr_q[7:0]; // RL2
                    upd_q <= 1'b1;
                    pl_hi_q <= !pl_hi_cur; // RL3
                    pl_first_q <= 1'b0;
                    if (!pl_hi_cur && !pl_first_cur) begin
                        addr_q <= addr_q + 1'b1; // RL4
                    end
                end
                if (ir_is(ir_i, jpd_pkg::IR_PREAD) && tap.capture) begin
                    pr_hi_q <= !pr_hi_cur; // RL5
                    if (pr_hi_cur) begin
                        addr_q <= addr_q + 1'b1; // RL6
                    end
                end
            end
        end
    end

    // the byte is queued the cycle after update; a full queue stalls nothing on the link,
    // so programmers must pace updates within the 11-clock write window
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fifo_in_valid_q <= 1'b0;
            fifo_in <= '0;
        end else if (clk_en_i) begin
            if (upd_q) begin
                fifo_in_valid_q <= 1'b1; // RL2
                fifo_in.hi <= !pl_hi_q;
                fifo_in.addr <= addr_q;
                fifo_in.data <= tmp_q;
            end else if (fifo_in_ready) begin
                fifo_in_valid_q <= 1'b0;
            end
        end
    end

    jpd_fifo #(
        .WIDTH(W),
        .DEPTH(jpd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .en_i(clk_en_i),
        .in_data_i(fifo_in),
        .in_valid_i(fifo_in_valid_q),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!device_reset_o)
    );

    // page buffer write port; drains one entry per cycle unless the core is in reset
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pbuf_we_o <= 1'b0;
            pbuf_hi_o <= 1'b0;
            pbuf_data_o <= '0;
            pbuf_addr_o <= '0;
        end else if (clk_en_i) begin
            pbuf_we_o <= fifo_out_valid && !device_reset_o; // RL2
            pbuf_hi_o <= fifo_out.hi;
            pbuf_data_o <= fifo_out.data;
            pbuf_addr_o <= fifo_out.addr;
        end
    end

    // tdo changes on the falling link edge from the selected register's lsb
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tdo_o <= 1'b0;
            flash_addr_o <= '0;
        end else if (clk_en_i) begin
            flash_addr_o <= addr_q;
            if (tck_fall) begin
                unique case (ir_i)
                    jpd_pkg::IR_UNLOCK: tdo_o <= unlock_q[0];
                    jpd_pkg::IR_RESET: tdo_o <= rst_chain_q;
                    default: tdo_o <= cmd_sr_q[0]; // RL16 RL18
                endcase
            end
        end
    end
endmodule

// ---- verif/jpd_chk.sv ----
// concurrent checks on the top module ports of the programming data path
`timescale 1ns/1ps
module jpd_chk (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic tck_i,
    input wire logic [3:0] tap_state_i,
    input wire logic [3:0] ir_i,
    input wire logic device_reset_o,
    input wire logic unlock_instr_o,
    input wire logic [14:0] cmd_o,
    input wire logic cmd_exec_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic pbuf_we_o,
    input wire logic pbuf_hi_o,
    input wire logic [15:0] pbuf_addr_o
);
    // 11 link clocks of 8 system clocks each
    localparam int PB_LIM = 88;
    logic [7:0] rst_cnt_q;
    logic [15:0] lo_addr_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // saturates so a long hold never wraps back under the time-out
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_cnt_q <= 8'h00;
        end else if (!device_reset_o) begin
            rst_cnt_q <= 8'h00;
        end else if (rst_cnt_q != 8'hff) begin
            rst_cnt_q <= rst_cnt_q + 8'h01;
        end
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lo_addr_q <= 16'h0000;
        end else if (pbuf_we_o && !pbuf_hi_o) begin
            lo_addr_q <= pbuf_addr_o;
        end
    end
    a_reset_timeout: assert property ($fell(device_reset_o) |-> rst_cnt_q >= 8'h40)
        else $error("core reset released before time-out");
    a_reset_cause: assert property ($rose(device_reset_o) |-> ir_i == jpd_pkg::IR_RESET)
        else $error("core reset raised outside reset chain");
    a_unlock_source: assert property ($changed(unlock_instr_o) |-> ir_i == jpd_pkg::IR_UNLOCK)
        else $error("programming enable changed outside unlock");
    a_unlock_por: assert property (disable iff (1'b0) !resetn_i |-> !unlock_instr_o)
        else $error("programming enable set during power-on reset");
    a_pbuf_gated: assert property (pbuf_we_o |-> unlock_instr_o)
        else $error("page buffer written while locked");
    a_pbuf_limit: assert property ($rose(tck_i) && tap_state_i[1] && !device_reset_o
        && ir_i == jpd_pkg::IR_PLOAD && unlock_instr_o |-> ##[1:PB_LIM] pbuf_we_o)
        else $error("page buffer write late after update");
    a_hi_pairs: assert property (pbuf_we_o && pbuf_hi_o |-> pbuf_addr_o == lo_addr_q)
        else $error("high byte address differs from low byte");
    a_addr_step: assert property ($changed(flash_addr_o) && ir_i[3:1] == 3'h3
        |-> flash_addr_o == $past(flash_addr_o) + 16'h0001)
        else $error("word address moved by other than one");
    a_cmd_source: assert property ($changed(cmd_o) |-> ir_i == jpd_pkg::IR_CMD)
        else $error("command changed outside command entry");
    a_exec_cause: assert property ($rose(tck_i) && tap_state_i[0] && ir_i == jpd_pkg::IR_CMD
        && unlock_instr_o |-> ##[1:7] cmd_exec_o)
        else $error("idle clock did not execute command");
    c_pbuf_hi: cover property (pbuf_we_o && pbuf_hi_o);
    c_reset_end: cover property ($fell(device_reset_o));
    c_exec: cover property (cmd_exec_o);
endmodule
bind jpd_top jpd_chk chk_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .tck_i(tck_i),
    .tap_state_i(tap_state_i), .ir_i(ir_i), .device_reset_o(device_reset_o),
    .unlock_instr_o(unlock_instr_o), .cmd_o(cmd_o), .cmd_exec_o(cmd_exec_o),
    .flash_addr_o(flash_addr_o), .pbuf_we_o(pbuf_we_o), .pbuf_hi_o(pbuf_hi_o),
    .pbuf_addr_o(pbuf_addr_o));

// ---- verif/jpd_prog_model.sv ----
// test-port programmer model: link clock, state decode, instruction and serial data
`timescale 1ns/1ps
module jpd_prog_model (
    input wire logic sys_clk_i,
    input wire logic tdo_i,
    output logic tck_o,
    output logic tdi_o,
    output logic [3:0] tap_state_o,
    output logic [3:0] ir_o
);
    initial begin
        tck_o = 1'b0;
        tdi_o = 1'b0;
        tap_state_o = 4'h0;
        ir_o = 4'h0;
    end
    // one 800 ns link clock; tdo taken mid-high, before the rise is seen inside
    task automatic tck_cyc(input logic [3:0] st, input logic d, output logic q);
        tap_state_o = st;
        tdi_o = d;
        repeat (4) @(negedge sys_clk_i);
        tck_o = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        q = tdo_i;
        repeat (2) @(negedge sys_clk_i);
        tck_o = 1'b0;
    endtask
    task automatic dr_scan(input logic [3:0] ir, input logic [15:0] din, input int n,
                           output logic [15:0] dout);
        logic q;
        @(negedge sys_clk_i);
        ir_o = ir;
        dout = 16'h0000;
        tck_cyc(4'h8, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tck_cyc(4'h4, din[i], dout[i]);
        end
        tck_cyc(4'h2, 1'b0, q);
        tap_state_o = 4'h0;
        // clock stands still between frames; data line must not look held
        tdi_o = ~tdi_o;
    endtask
    task automatic idle_cyc(input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            tck_cyc(4'h1, tdi_o, q);
        end
        tap_state_o = 4'h0;
    endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the programming data path
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_i = 1'b1;
    logic resetn_i = 1'b1;
    logic tck_i, tdi_i, tdo_o, device_reset_o, unlock_instr_o, cmd_exec_o, pbuf_we_o, pbuf_hi_o;
    logic [3:0] tap_state_i, ir_i;
    logic [7:0] cmd_result_i = 8'h00;
    logic [7:0] flash_rdata_i = 8'h00;
    logic [7:0] pbuf_data_o;
    logic [14:0] cmd_o;
    logic [15:0] flash_addr_o, pbuf_addr_o;
    int err_total = 0;
    int cmp_count = 0;
    int exec_n = 0;
    jpd_pkg::jpd_pbuf_t got_q[$];
    jpd_pkg::jpd_pbuf_t exp_q[$];
    localparam logic [15:0] BASE = 16'h013e;
    localparam logic [14:0] SEQ [36] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h3380,
        15'h2310, 15'h0b00, 15'h0701, 15'h033e, 15'h13a5, 15'h175a, 15'h3700, 15'h7700,
        15'h3700, 15'h3700, 15'h3500, 15'h3700, 15'h3700, 15'h2311, 15'h0701, 15'h033e,
        15'h1366, 15'h3700, 15'h7700, 15'h3700, 15'h3300, 15'h3100, 15'h3300, 15'h3300,
        15'h2302, 15'h0b00, 15'h0701, 15'h033e, 15'h3200, 15'h3600, 15'h3700};
    always #(jpd_pkg::CLK_NS / 2) sys_clk_i = ~sys_clk_i;
    jpd_top dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .tck_i(tck_i),
        .tdi_i(tdi_i), .tap_state_i(tap_state_i), .ir_i(ir_i), .cmd_result_i(cmd_result_i),
        .flash_rdata_i(flash_rdata_i), .tdo_o(tdo_o), .device_reset_o(device_reset_o),
        .unlock_instr_o(unlock_instr_o), .cmd_o(cmd_o), .cmd_exec_o(cmd_exec_o),
        .flash_addr_o(flash_addr_o), .pbuf_we_o(pbuf_we_o), .pbuf_hi_o(pbuf_hi_o),
        .pbuf_data_o(pbuf_data_o), .pbuf_addr_o(pbuf_addr_o));
    jpd_prog_model prog_u (.sys_clk_i(sys_clk_i), .tdo_i(tdo_o), .tck_o(tck_i), .tdi_o(tdi_i),
        .tap_state_o(tap_state_i), .ir_o(ir_i));
    always @(posedge sys_clk_i) begin
        if (cmd_exec_o === 1'b1) exec_n++;
        if (pbuf_we_o === 1'b1) got_q.push_back({pbuf_hi_o, pbuf_addr_o, pbuf_data_o});
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_unlock();
        logic [15:0] d;
        prog_u.dr_scan(jpd_pkg::IR_RESET, 16'h0001, 1, d);
        chk(device_reset_o, 1'b1);
        prog_u.dr_scan(jpd_pkg::IR_UNLOCK, jpd_pkg::UNLOCK_SIG ^ 16'h8000, 16, d);
        chk(unlock_instr_o, 1'b0);
        prog_u.dr_scan(jpd_pkg::IR_UNLOCK, jpd_pkg::UNLOCK_SIG, 16, d);
        chk(unlock_instr_o, 1'b1);
        prog_u.dr_scan(jpd_pkg::IR_RESET, 16'h0000, 1, d);
        repeat (40) @(negedge sys_clk_i);
        chk(device_reset_o, 1'b1);
        repeat (40) @(negedge sys_clk_i);
        chk(device_reset_o, 1'b0);
    endtask
    task automatic cmd(input logic [14:0] v);
        logic [15:0] d;
        int n0;
        cmd_result_i = v[7:0] ^ 8'h5a;
        n0 = exec_n;
        prog_u.dr_scan(jpd_pkg::IR_CMD, {1'b0, v}, jpd_pkg::CMD_W, d);
        chk(cmd_o, v);
        chk(d[7:0], v[7:0] ^ 8'h5a);
        prog_u.idle_cyc(1);
        // the execute pulse lands a few system clocks after the link rise
        repeat (2) @(negedge sys_clk_i);
        chk(exec_n - n0, 1);
    endtask
    task automatic t_lock();
        logic [15:0] d;
        prog_u.dr_scan(jpd_pkg::IR_UNLOCK, jpd_pkg::UNLOCK_RST, jpd_pkg::UNLOCK_W, d);
        chk(unlock_instr_o, 1'b0);
    endtask
    task automatic t_page_load();
        logic [15:0] d;
        logic [7:0] prev;
        jpd_pkg::jpd_pbuf_t e;
        prev = 8'h00;
        for (int k = 0; k < 4; k++) begin
            prog_u.dr_scan(jpd_pkg::IR_PLOAD, 16'(8'h30 + k), jpd_pkg::BYTE_W, d);
            chk(d[7:0], prev);
            prev = 8'(8'h30 + k);
            e.hi = k[0];
            e.addr = BASE + 16'(k / 2);
            e.data = prev;
            exp_q.push_back(e);
        end
        repeat (100) @(negedge sys_clk_i);
        chk(got_q.size(), 4);
        for (int i = 0; i < 4 && i < got_q.size(); i++) chk(got_q[i], exp_q[i]);
        chk(flash_addr_o, BASE + 16'h0001);
    endtask
    task automatic t_page_read();
        logic [15:0] d;
        cmd(15'h0701);
        cmd(15'h033e);
        for (int k = 0; k < 4; k++) begin
            flash_rdata_i = 8'hc0 + 8'(k);
            prog_u.dr_scan(jpd_pkg::IR_PREAD, 16'h0000, jpd_pkg::BYTE_W, d);
            chk(d[7:0], 8'hc0 + 8'(k));
            chk(flash_addr_o, BASE + 16'((k + 1) / 2));
        end
    endtask
    initial begin
        // drop reset on a real edge so every flop with a reset starts defined before the first clock
        @(negedge sys_clk_i);
        resetn_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        chk(unlock_instr_o, 1'b0);
        t_unlock();
        for (int i = 0; i < 36; i++) cmd(SEQ[i]);
        chk(flash_addr_o, BASE);
        t_page_load();
        t_page_read();
        resetn_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        chk(unlock_instr_o, 1'b0);
        resetn_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        t_unlock();
        t_lock();
        final_report();
    end
    initial begin
        #3_000_000;
        err_total++;
        final_report();
    end
endmodule
